//--- hdl/slpi_core.v
// serial peripheral with wait/halt behaviour, interrupt routing and wishbone registers
// Operation
// - wait mode: keeps running, events wake CPU
// - halt mode: inactive, registers frozen except a slave selected at halt entry keeps shifting
// - slave transfer-complete wakes halt; others wait only
// - several bytes while halted sets overrun
// - halt wake needs select low at entry
// - events share one vector, gated by enables
// - interrupt enable gates complete, fault, overrun
// - peripheral enable connects pins, cleared on fault
// - master select drives clock, swaps data pins
// - polarity sets clock idle level
// - phase picks first or second capture edge
// - three rate bits pick master divider
// - divider enable bit cleared by reset
// - complete flag set at end, cleared by sequence
// - data writes ignored while complete until status accessed
// - collision flag on data write during transfer
// - overrun when byte ready while complete set
// - mode fault when select low as master
// - master data write starts byte; reads buffer
// - software select bit drives internal select
`timescale 1ns/1ns
`default_nettype none
`include "slpi_regs.vh"
module slpi_core (
    input  wire       i_core_clk,   // cpu clock, 125 MHz
    input  wire       i_srst,       // synchronous reset, high
    input  wire       i_cpu_halt,   // cpu is in halt mode
    input  wire       i_cpu_wait,   // cpu is in wait mode
    input  wire       i_cpu_imask,  // cpu interrupt mask, 1 masks
    input  wire       i_wb_cyc,     // wishbone cycle
    input  wire       i_wb_stb,     // wishbone strobe
    input  wire       i_wb_we,      // wishbone write
    input  wire [3:0] i_wb_adr,     // wishbone byte address
    input  wire [3:0] i_wb_sel,     // wishbone byte enables
    input  wire [31:0] i_wb_dat,    // wishbone write data
    output reg  [31:0] o_wb_dat,    // wishbone read data
    output reg        o_wb_ack,     // wishbone acknowledge
    output reg        o_wb_err,     // wishbone error, unmapped
    output wire       o_irq,        // shared serial interrupt
    output wire       o_wake_wait,  // wake request out of wait
    output wire       o_wake_halt,  // wake request out of halt
    input  wire       i_sck,        // serial clock pin in
    output reg        o_sck,        // serial clock pin out
    output wire       o_sck_oe_n,   // serial clock drive, low drives
    input  wire       i_mosi,       // mosi pin in
    output wire       o_mosi,       // mosi pin out
    output wire       o_mosi_oe_n,  // mosi drive, low drives
    input  wire       i_miso,       // miso pin in
    output wire       o_miso,       // miso pin out
    output wire       o_miso_oe_n,  // miso drive, low drives
    input  wire       i_ss_n        // slave select pin, low selects
);
    // ****************************************************
    // registers and state
    // ****************************************************
    reg [7:0] ctrl_q;
    reg       tc_q, write_collision_flag_q, ovr_q, mode_fault_flag_q;
    reg [2:0] csr_lo_q;           // sod, ssm, ssi
    reg [7:0] shift_q, rxbuf_q;
    reg [3:0] bitcnt_q;
    reg       busy_q;
    reg       phase_q;            // 0: next edge is leading
    reg [6:0] div_q;
    reg       csr_seen_q;         // status accessed while flag set
    reg       mode_fault_flag_seen_q;
    reg       sck_s_q;
    reg       halt_ss_q;          // select level latched at halt entry
    reg       halt_q;
    reg       halt_rx_q;          // a byte completed during halt
    reg       out_bit_q;

    wire pe    = ctrl_q[`SLPI_CR_PE];
    wire master_select_bit  = ctrl_q[`SLPI_CR_MASTER_SELECT_BIT];
    wire clock_polarity_bit  = ctrl_q[`SLPI_CR_CLOCK_POLARITY_BIT];
    wire clock_phase_bit  = ctrl_q[`SLPI_CR_CLOCK_PHASE_BIT];
    wire select_management_bit   = csr_lo_q[`SLPI_CSR_SSM];
    wire software_select_bit   = csr_lo_q[`SLPI_CSR_SSI];
    wire sod   = csr_lo_q[`SLPI_CSR_SOD];
    wire ss_int = select_management_bit ? software_select_bit : i_ss_n;
    wire [2:0] rate = {ctrl_q[`SLPI_CR_DIVEN], ctrl_q[1:0]};

    // ****************************************************
    // wishbone slave
    // ****************************************************
    wire req     = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
    wire a_data  = i_wb_adr[3:2] == `SLPI_ADDR_DATA;
    wire a_ctrl  = i_wb_adr[3:2] == `SLPI_ADDR_CTRL;
    wire a_csr   = i_wb_adr[3:2] == `SLPI_ADDR_CSR;
    wire mapped  = a_data | a_ctrl | a_csr;
    wire wr_b0   = req & i_wb_we & i_wb_sel[0];
    wire data_wr = wr_b0 & a_data;
    wire data_rd = req & ~i_wb_we & a_data;
    wire ctrl_wr = wr_b0 & a_ctrl;
    wire csr_rd  = req & ~i_wb_we & a_csr;
    wire csr_acc = req & a_csr;
    wire [7:0] csr_val = {tc_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, csr_lo_q};

    // ****************************************************
    // master clock divider
    // ****************************************************
    reg [6:0] half;
    always @* begin
        case (rate)
            3'h4:    half = `SLPI_HALF_4;
            3'h0:    half = `SLPI_HALF_8;
            3'h1:    half = `SLPI_HALF_16;
            3'h6:    half = `SLPI_HALF_32;
            3'h2:    half = `SLPI_HALF_64;
            3'h3:    half = `SLPI_HALF_128;
            default: half = `SLPI_HALF_128; // unlisted codes: slowest
        endcase
    end
    wire m_tick = busy_q & master_select_bit & (div_q == half);

    // ****************************************************
    // edge detection; slave edges come from the pin
    // ****************************************************
    wire s_edge = ~master_select_bit & ~ss_int & (sck_s_q != i_sck);
    wire edge_ev = pe & busy_q & (master_select_bit ? m_tick : s_edge);
    // capture on leading edge when phase 0, trailing when phase 1
    wire cap_edge = edge_ev & (phase_q == clock_phase_bit);
    wire sh_edge  = edge_ev & (phase_q != clock_phase_bit);
    wire din = master_select_bit ? i_miso : i_mosi;
    wire [7:0] shift_cap = {shift_q[6:0], din};
    wire last_cap = cap_edge & (bitcnt_q == `SLPI_BITS - 4'h1);
    // byte ends on its last capture edge (phase 0 trails one edge, absorbed)
    wire done = last_cap;

    wire frozen = i_cpu_halt;
    // in halt a selected slave still shifts so the byte can wake the cpu
    wire run_ok = ~frozen | (~master_select_bit & ~halt_ss_q);
    wire tc_ok_clear = csr_seen_q & (data_rd | data_wr);
    wire wr_blocked = tc_q & ~csr_seen_q;
    wire wr_coll = data_wr & busy_q & ~(~master_select_bit & ~bitcnt_q[3] & bitcnt_q == 4'h0 & ~phase_q);
    wire mode_fault_flag_ev = pe & master_select_bit & ~ss_int;
    wire m_start = ~frozen & data_wr & ~wr_coll & ~wr_blocked & pe & master_select_bit;
    localparam [7:0] CSR_RST = `SLPI_CSR_RESET;
    wire [7:0] csr_wr_val = i_wb_dat[7:0] & `SLPI_CSR_WMASK;

    // ****************************************************
    // read data and bus answer
    // ****************************************************
    reg [7:0] rd_byte;
    always @* begin
        case (i_wb_adr[3:2])
            `SLPI_ADDR_DATA: rd_byte = rxbuf_q;
            `SLPI_ADDR_CTRL: rd_byte = ctrl_q;
            `SLPI_ADDR_CSR:  rd_byte = csr_val;
            default:         rd_byte = 8'h00;
        endcase
    end

    // no ack while halted: mapped accesses are frozen, unmapped ones still get an error
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_wb_ack <= 1'b0;
            o_wb_err <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= req & mapped & ~frozen;
            o_wb_err <= req & ~mapped;
            if (~frozen & req & mapped) begin
                o_wb_dat <= {24'h000000, (i_wb_we ? 8'h00 : rd_byte)};
            end
        end
    end

    // ****************************************************
    // halt entry tracking
    // ****************************************************
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            halt_q    <= 1'b0;
            halt_ss_q <= 1'b1;
            halt_rx_q <= 1'b0;
        end else begin
            halt_q <= frozen;
            if (frozen & ~halt_q) begin
                halt_ss_q <= ss_int;
                halt_rx_q <= 1'b0;
            end
            // a second byte in halt must raise overrun
            if (busy_q & run_ok & done & frozen) begin
                halt_rx_q <= 1'b1;
            end
        end
    end

    // ****************************************************
    // master divider and clock pin
    // ****************************************************
    always @(posedge i_core_clk) begin
        if (i_srst | m_start) begin
            div_q <= 7'h00;
        end else if (busy_q & master_select_bit & run_ok) begin
            if (m_tick) begin
                div_q <= 7'h00;
            end else begin
                div_q <= div_q + 7'h01;
            end
        end
    end

    // idle level wins whenever no master byte runs
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_sck <= 1'b0;
        end else if (~busy_q | ~master_select_bit) begin
            o_sck <= clock_polarity_bit;
        end else if (run_ok & edge_ev) begin
            o_sck <= ~o_sck;
        end
    end

    // pin level tracker; reset loads low, then it follows the pin every cycle
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            sck_s_q <= 1'b0;
        end else begin
            sck_s_q <= i_sck;
        end
    end

    // ****************************************************
    // serial engine and status flags
    // ****************************************************
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            ctrl_q <= `SLPI_CR_RESET;
            {tc_q, write_collision_flag_q, ovr_q, mode_fault_flag_q} <= 4'h0;
            csr_lo_q <= CSR_RST[2:0];
            shift_q <= 8'h00;
            rxbuf_q <= 8'h00;
            bitcnt_q <= 4'h0;
            busy_q <= 1'b0;
            phase_q <= 1'b0;
            csr_seen_q <= 1'b0;
            mode_fault_flag_seen_q <= 1'b0;
            out_bit_q <= 1'b0;
        end else begin
            if (~frozen & req & mapped) begin
                // status access arms the clear sequences
                if (csr_acc & (tc_q | write_collision_flag_q)) csr_seen_q <= 1'b1;
                if (csr_rd & mode_fault_flag_q) mode_fault_flag_seen_q <= 1'b1;
                if (csr_rd) ovr_q <= 1'b0;
                if (tc_ok_clear) begin
                    csr_seen_q <= 1'b0;
                    tc_q <= 1'b0;
                    if (data_rd) write_collision_flag_q <= 1'b0;
                end
                if (wr_b0 & a_csr) csr_lo_q <= csr_wr_val[2:0];
                if (ctrl_wr) begin
                    ctrl_q <= i_wb_dat[7:0];
                    // enable and master stay off while fault stands outside clearing
                    if (mode_fault_flag_q & ~mode_fault_flag_seen_q) begin
                        ctrl_q[`SLPI_CR_PE] <= 1'b0;
                        ctrl_q[`SLPI_CR_MASTER_SELECT_BIT] <= 1'b0;
                    end
                    if (mode_fault_flag_seen_q) begin
                        mode_fault_flag_q <= 1'b0;
                        mode_fault_flag_seen_q <= 1'b0;
                    end
                end
                if (data_wr) begin
                    // a slave that is selected but not yet clocked may still take a byte
                    if (wr_coll)
                        write_collision_flag_q <= 1'b1;
                    else if (~wr_blocked & pe) begin
                        shift_q <= i_wb_dat[7:0];
                        out_bit_q <= i_wb_dat[7];
                        if (master_select_bit) begin
                            busy_q <= 1'b1;
                            bitcnt_q <= 4'h0;
                            phase_q <= 1'b0;
                        end
                    end
                end
            end
            // slave becomes busy when selected and enabled
            if (pe & ~master_select_bit & ~ss_int & ~busy_q & run_ok) begin
                busy_q <= 1'b1;
                bitcnt_q <= 4'h0;
                phase_q <= 1'b0;
                out_bit_q <= shift_q[7];
            end
            if (~master_select_bit & ss_int & ~clock_phase_bit & busy_q & bitcnt_q == 4'h0 & ~phase_q)
                busy_q <= 1'b0;
            if (busy_q & run_ok) begin
                if (edge_ev) begin
                    phase_q <= ~phase_q;
                end
                if (cap_edge) begin
                    shift_q <= shift_cap;
                    bitcnt_q <= bitcnt_q + 4'h1;
                end
                if (sh_edge) out_bit_q <= shift_q[7];
                if (done) begin
                    // while the flag stands the buffer keeps the first byte; later ones are lost
                    if (~tc_q) rxbuf_q <= shift_cap;
                    // a phase-0 slave stays busy so the trailing clock edge is not
                    // taken as the first capture of the next byte
                    busy_q <= ~(master_select_bit | clock_phase_bit);
                    phase_q <= ~(master_select_bit | clock_phase_bit);
                    bitcnt_q <= 4'h0;
                    tc_q <= 1'b1;
                    if (tc_q | (frozen & halt_rx_q)) ovr_q <= 1'b1;
                end
            end
            if (mode_fault_flag_ev & ~frozen) begin
                mode_fault_flag_q <= 1'b1;
                ctrl_q[`SLPI_CR_PE] <= 1'b0;
                ctrl_q[`SLPI_CR_MASTER_SELECT_BIT] <= 1'b0;
                busy_q <= 1'b0;
            end
            if (~pe) busy_q <= 1'b0;
        end
    end

    // ****************************************************
    // pins
    // ****************************************************
    assign o_sck_oe_n  = ~(pe & master_select_bit);
    assign o_mosi      = out_bit_q;
    assign o_miso      = out_bit_q;
    assign o_mosi_oe_n = ~(pe & master_select_bit & ~sod);
    assign o_miso_oe_n = ~(pe & ~master_select_bit & ~sod & ~ss_int);

    // ****************************************************
    // interrupts and wake
    // ****************************************************
    wire ie = ctrl_q[`SLPI_CR_IE];
    wire ev_any = tc_q | mode_fault_flag_q | ovr_q;
    assign o_irq       = ie & ev_any & ~i_cpu_imask;
    assign o_wake_wait = i_cpu_wait & ie & ev_any;
    // only the completion of a selected slave byte leaves halt
    assign o_wake_halt = i_cpu_halt & ie & tc_q & ~master_select_bit & ~halt_ss_q;
endmodule
`default_nettype wire

//--- hdl/slpi_regs.vh
// register map, field positions and constants of the low-power serial peripheral
`ifndef SLPI_REGS_VH
`define SLPI_REGS_VH
`define SLPI_ADDR_DATA    2'h0
`define SLPI_ADDR_CTRL    2'h1
`define SLPI_ADDR_CSR     2'h2
`define SLPI_CR_IE        7
`define SLPI_CR_PE        6
`define SLPI_CR_DIVEN     5
`define SLPI_CR_MASTER_SELECT_BIT      4
`define SLPI_CR_CLOCK_POLARITY_BIT      3
`define SLPI_CR_CLOCK_PHASE_BIT      2
`define SLPI_CSR_TC       7
`define SLPI_CSR_WRITE_COLLISION_FLAG     6
`define SLPI_CSR_OVR      5
`define SLPI_CSR_MODE_FAULT_FLAG     4
`define SLPI_CSR_SOD      2
`define SLPI_CSR_SSM      1
`define SLPI_CSR_SSI      0
`define SLPI_CR_RESET     8'h00
`define SLPI_CSR_RESET    8'h00
`define SLPI_CSR_WMASK    8'h07
`define SLPI_BITS         4'h8
`define SLPI_HALF_4       7'h01
`define SLPI_HALF_8       7'h03
`define SLPI_HALF_16      7'h07
`define SLPI_HALF_32      7'h0F
`define SLPI_HALF_64      7'h1F
`define SLPI_HALF_128     7'h3F
`endif

//--- dv/slpi_chk.sv
// port-level assertion checker for the low-power serial core
`timescale 1ns/1ns
`default_nettype none
module slpi_chk (
    input wire logic i_core_clk,  // clock
    input wire logic i_srst,      // reset
    input wire logic i_cpu_halt,  // halt
    input wire logic i_cpu_wait,  // wait
    input wire logic i_cpu_imask, // mask
    input wire logic i_wb_cyc,    // cycle
    input wire logic i_wb_stb,    // strobe
    input wire logic o_wb_ack,    // ack
    input wire logic o_wb_err,    // error
    input wire logic o_irq,       // interrupt
    input wire logic o_wake_wait, // wake from wait
    input wire logic o_wake_halt, // wake from halt
    input wire logic o_sck,       // clock out
    input wire logic o_sck_oe_n,  // clock drive
    input wire logic o_mosi_oe_n, // mosi drive
    input wire logic o_miso_oe_n, // miso drive
    input wire logic i_ss_n       // select
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    AST_IRQ_MASK: assert property (o_irq |-> !i_cpu_imask)
        else $error("irq while masked");
    AST_ACK_TIME: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err && !i_cpu_halt
        |=> o_wb_ack || o_wb_err) else $error("no answer one cycle after request");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    AST_HALT_FROZEN: assert property (i_cpu_halt && $past(i_cpu_halt) |-> !o_wb_ack && $stable(o_sck_oe_n))
        else $error("activity while halted");
    AST_MASTER_PINS: assert property (!o_sck_oe_n |-> !o_mosi_oe_n && o_miso_oe_n)
        else $error("master pin roles wrong");
    AST_SLAVE_PINS: assert property (!o_miso_oe_n |-> o_sck_oe_n && o_mosi_oe_n)
        else $error("slave pin roles wrong");
    AST_MODE_FAULT: assert property (!o_sck_oe_n && !i_ss_n |-> ##[1:4] o_sck_oe_n)
        else $error("master kept pins on select low");
    AST_WAKE_WAIT: assert property (o_irq && i_cpu_wait |-> o_wake_wait)
        else $error("irq without wait wake");
    AST_WAKE_HALT: assert property (o_wake_halt |-> o_sck_oe_n)
        else $error("halt wake outside slave mode");
    AST_RESET: assert property (disable iff (1'b0) i_srst |=> !o_wb_ack && !o_irq && o_sck_oe_n && !o_sck)
        else $error("outputs not reset");
endmodule
bind slpi_core slpi_chk u_chk (.*);
`default_nettype wire

//--- dv/slpi_peer.sv
// behavioural far-side serial master, mode 0, for driving the core as slave
`timescale 1ns/1ns
`default_nettype none
module slpi_peer (
    input  wire logic       i_clk,  // bench clock
    input  wire logic       i_go,   // start one byte
    input  wire logic       i_sel,  // hold select low
    input  wire logic [7:0] i_byte, // byte to send
    input  wire logic       i_miso, // data from core
    output logic            o_sck,  // serial clock, idle low
    output logic            o_mosi, // data to core
    output logic            o_ss_n, // select, low active
    output logic            o_done, // byte finished
    output logic [7:0]      o_rx    // byte captured
);
    logic [6:0] cnt;
    logic [7:0] sh;
    assign o_ss_n = ~i_sel;
    initial begin
        cnt = 7'h00;
        o_sck = 1'b0;
        o_mosi = 1'b0;
        o_done = 1'b0;
    end
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (cnt == 7'h00) begin
            if (i_go) begin
                cnt <= 7'h01;
                sh <= i_byte;
                o_mosi <= i_byte[7];
            end
        end else begin
            cnt <= cnt + 7'h01;
            if (cnt[1:0] == 2'h0) begin
                o_sck <= ~o_sck;
                if (!o_sck) o_rx <= {o_rx[6:0], i_miso};
                else begin
                    sh <= {sh[6:0], 1'b0};
                    o_mosi <= sh[6];
                end
            end
            // after the frame the line no longer holds the last bit
            if (cnt == 7'h40) begin
                cnt <= 7'h00;
                o_done <= 1'b1;
                o_mosi <= ~o_mosi;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the low-power serial core
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk, srst, halt, wt, imask, cyc, stb, we, go, sel, ack, err, e, irq, wkw, wkh;
    logic        sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, p_sck, p_mosi, ss_n, done;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  pbyte, prx, r;
    int          errors, num_checks, tick;
    wire         l_sck  = sck_oe_n ? p_sck : sck;
    wire         l_mosi = mosi_oe_n ? p_mosi : mosi;
    wire         l_miso = miso_oe_n ? mosi : miso; // far slave echoes the master data line
    slpi_core u_slpi_core (.i_core_clk(clk), .i_srst(srst), .i_cpu_halt(halt), .i_cpu_wait(wt),
        .i_cpu_imask(imask), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err), .o_irq(irq),
        .o_wake_wait(wkw), .o_wake_halt(wkh), .i_sck(l_sck), .o_sck(sck), .o_sck_oe_n(sck_oe_n),
        .i_mosi(l_mosi), .o_mosi(mosi), .o_mosi_oe_n(mosi_oe_n), .i_miso(l_miso), .o_miso(miso),
        .o_miso_oe_n(miso_oe_n), .i_ss_n(ss_n));
    slpi_peer u_slpi_peer (.i_clk(clk), .i_go(go), .i_sel(sel), .i_byte(pbyte), .i_miso(l_miso),
        .o_sck(p_sck), .o_mosi(p_mosi), .o_ss_n(ss_n), .o_done(done), .o_rx(prx));
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h000000, d};
        do @(posedge clk); while (!(ack || err));
        r = rdat[7:0];
        e = err;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] x);
        wb(1'b0, a, 8'h00);
        chk(r, x);
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        pbyte <= b; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (!done);
    endtask
    task automatic t_regs;
        rc(4'h4, 8'h00);
        wb(1'b1, 4'h8, 8'h00);
        rc(4'h8, 8'h00);
        wb(1'b0, 4'hC, 8'h00);
        chk({7'h00, e}, 8'h01);
    endtask
    task automatic t_rates;
        logic [2:0] c [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
        int n, d;
        for (int i = 0; i < 6; i++) begin
            d = 4 << i;
            wb(1'b1, 4'h4, {2'h3, c[i][2], 3'h4, c[i][1:0]});
            n = tick;
            wb(1'b1, 4'h0, 8'hA5 + i[7:0]);
            if (i == 0) wb(1'b1, 4'h0, 8'hFF);
            while (!irq && tick - n < 2000) @(posedge clk);
            n = tick - n;
            chk({7'h00, n >= 7 * d && n <= 8 * d + 8}, 8'h01);
            imask <= 1'b1;
            @(posedge clk);
            @(posedge clk);
            chk({7'h00, irq}, 8'h00);
            imask <= 1'b0;
            rc(4'h8, (i == 0) ? 8'hC0 : 8'h80);
            rc(4'h0, 8'hA5 + i[7:0]);
            rc(4'h8, 8'h00);
        end
        wb(1'b1, 4'h4, 8'h00);
        wb(1'b1, 4'h4, 8'h58);
        @(negedge clk);
        chk({7'h00, sck}, 8'h01);
        wb(1'b1, 4'h4, 8'h00);
    endtask
    task automatic t_fault;
        wb(1'b1, 4'h4, 8'hD0);
        sel <= 1'b1;
        repeat (4) @(posedge clk);
        chk({6'h00, sck_oe_n, irq}, 8'h03);
        rc(4'h8, 8'h10);
        rc(4'h4, 8'h80);
        sel <= 1'b0;
        wb(1'b1, 4'h4, 8'h00);
        rc(4'h8, 8'h00);
    endtask
    task automatic t_halt;
        wb(1'b1, 4'h4, 8'hC0);
        wb(1'b1, 4'h0, 8'h5A);
        sel <= 1'b1;
        repeat (4) @(posedge clk);
        halt <= 1'b1;
        send(8'h3C);
        chk(prx, 8'h5A);
        chk({7'h00, wkh}, 8'h01);
        send(8'h96);
        halt <= 1'b0;
        wt <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk({7'h00, wkw}, 8'h01);
        rc(4'h8, 8'hA0);
        rc(4'h0, 8'h3C);
        rc(4'h8, 8'h00);
        send(8'h11);
        rc(4'h8, 8'h80);
        rc(4'h0, 8'h11);
        sel <= 1'b0;
        @(posedge clk);
        halt <= 1'b1;
        repeat (2) @(posedge clk);
        sel <= 1'b1;
        send(8'h77);
        chk({7'h00, wkh}, 8'h00);
        halt <= 1'b0;
    endtask
    task automatic test_done;
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        tick++;
        if (tick == 20000) begin
            errors++;
            test_done;
        end
    end
    initial begin
        {srst, halt, wt, imask, cyc, stb, we, go, sel, pbyte, adr, wdat} = '0;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_rates;
        t_fault;
        t_halt;
        test_done;
    end
endmodule
`default_nettype wire
